// ===== sgs_consts.svh
// constants for the station global status word: bit positions, field
// bounds, masks and reset values; included by the priority encoder, the status word module and the bench
`ifndef SGS_CONSTS_SVH
`define SGS_CONSTS_SVH

// upper byte of the word
`define SGS_BIT_ACTIVE 15
`define SGS_BIT_SIM 14
`define SGS_BIT_FAULT 13
`define SGS_BIT_MODF 12
`define SGS_CODE_HI 11
`define SGS_CODE_LO 8
// lower byte of the word
`define SGS_BIT_MULTI 7
`define SGS_BIT_BUSY 6
`define SGS_INFO_HI 5
`define SGS_INFO_LO 0
`define SGS_INFO_W 6
`define SGS_INFO_MAX 6'h3f
`define SGS_INFO_ZERO 6'h00

// widths of the word and of the source vectors
`define SGS_WORD_W 16
`define SGS_CODE_W 4
`define SGS_SLOT_NUM 64
`define SGS_SUPPLY_NUM 6
`define SGS_CNT_W 7
`define SGS_CNT_ONE 7'h01
`define SGS_CNT_SAT 7'h3f

// general error codes a source may raise: 1..5 and 8..e
`define SGS_GEN_MASK 16'h7f3e
`define SGS_RESET_WORD 16'h0000

// cyclic input image: byte indices of the status word
`define SGS_BYTE_HI_IDX 8'h00
`define SGS_BYTE_LO_IDX 8'h01
`define SGS_HDR_BYTES 8'h02
`define SGS_BYTE_ZERO 8'h00

`endif

// ===== sgs_pkg.sv
// types for the station global status word
// assumes sgs_consts.svh is on the include path
package sgs_pkg;

  // error codes placed in bits 11..8; 4'hf is reserved and never produced
  typedef enum logic [3:0] {
    SGS_ERR_NONE = 4'h0,
    SGS_ERR_IF_RAM = 4'h1,
    SGS_ERR_IF_REG = 4'h2,
    SGS_ERR_IF_FLASH = 4'h3,
    SGS_ERR_IF_INT = 4'h4,
    SGS_ERR_IF_CMD = 4'h5,
    SGS_ERR_MODULE = 4'h6,
    SGS_ERR_SUPPLY = 4'h7,
    SGS_ERR_MP_RAM = 4'h8,
    SGS_ERR_MP_FLASH = 4'h9,
    SGS_ERR_MP_WDOG = 4'ha,
    SGS_ERR_RED_ARITH = 4'hb,
    SGS_ERR_RED_ABSENT = 4'hc,
    SGS_ERR_RED_LINK = 4'hd,
    SGS_ERR_RED_PARAM = 4'he,
    SGS_ERR_RESERVED = 4'hf
  } sgs_err_code_type;

endpackage

// ===== sgs_err_prio.sv
// priority encoder for pending error codes
// assumes pending bits are indexed by error code, same clock domain
`timescale 1ns/1ps
`include "sgs_consts.svh"

module sgs_err_prio (
  // pending errors, bit n set when code n is pending
  input wire logic [15:0] pend,
  // winning code and any-pending flag
  output sgs_pkg::sgs_err_code_type code,
  output logic any
);

  // lowest code number wins; the reserved code is never considered
  always_comb begin
    code = sgs_pkg::SGS_ERR_NONE;
    any = 1'b0;
    for (int i = 14; i >= 1; i--) begin
      if (pend[i]) begin
        code = sgs_pkg::sgs_err_code_type'(i[3:0]);
        any = 1'b1;
      end
    end
  end

endmodule

// ===== sgs_status_word.sv
// station global status word: assembles the 16-bit word from the head's
// condition inputs and serves it as the first two cyclic input bytes
// assumes all condition inputs come from logic on sys_clk
`timescale 1ns/1ps
`include "sgs_consts.svh"

module sgs_status_word (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // head conditions
  input wire logic head_active,
  input wire logic sim_active,
  input wire logic param_busy,
  // error sources
  input wire logic [15:0] gen_err_pend,
  input wire logic [`SGS_SLOT_NUM-1:0] slot_fault,
  input wire logic [`SGS_SUPPLY_NUM-1:0] supply_fault,
  // bus parameter: include the word in cyclic input
  input wire logic status_en,
  // cyclic input byte read port
  input wire logic rd_req,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data_r,
  output logic rd_ack_r,
  // downstream module input image
  output logic [7:0] app_rd_addr,
  input wire logic [7:0] app_rd_data,
  // assembled word
  output logic [15:0] status_word_r
);

  // count of set bits, used for every source group
  function automatic logic [6:0] ones(input logic [63:0] v);
    logic [6:0] n;
    n = 7'h00;
    for (int i = 0; i < 64; i++) begin
      n = n + {6'h00, v[i]};
    end
    return n;
  endfunction

  // index of the lowest set slot bit
  function automatic logic [5:0] first_slot(input logic [63:0] v);
    logic [5:0] s;
    s = 6'h00;
    for (int i = 63; i >= 0; i--) begin
      if (v[i]) begin
        s = 6'(i);
      end
    end
    return s;
  endfunction

  // pending vector by code; module and supply codes come from their maps
  logic [15:0] pend;
  // winning code and its valid flag
  sgs_pkg::sgs_err_code_type top_code;
  logic any_err;
  // per-group counts
  logic [6:0] n_gen;
  logic [6:0] n_slot;
  logic [6:0] n_sup;
  logic [6:0] n_all;
  // classification of the pending set
  logic only_supply;
  logic multi;
  // lower field and next word
  logic [5:0] info;
  logic [15:0] status_word_nxt;

  // general sources only on codes they may carry; f is masked away
  always_comb begin
    pend = gen_err_pend & `SGS_GEN_MASK;
    pend[sgs_pkg::SGS_ERR_MODULE] = |slot_fault;
    pend[sgs_pkg::SGS_ERR_SUPPLY] = |supply_fault;
  end

  // priority pick of the code shown in bits 11..8
  sgs_err_prio u_prio (
    .pend(pend),
    .code(top_code),
    .any(any_err)
  );

  // counts; each slot and each supply is one error of its own
  always_comb begin
    n_gen = ones({48'h0, gen_err_pend & `SGS_GEN_MASK});
    n_slot = ones(slot_fault);
    n_sup = ones({58'h0, supply_fault});
    n_all = n_gen + n_slot + n_sup;
  end

  // supply-only faults report as one error with a per-supply map
  always_comb begin
    only_supply = (n_sup != 7'h00) && (n_gen == 7'h00) && (n_slot == 7'h00);
    multi = !only_supply && (n_all > `SGS_CNT_ONE);
  end

  // low six bits: map, count, slot or zero
  always_comb begin
    if (only_supply) begin
      info = supply_fault;
    end else if (multi) begin
      // saturate: more than 63 errors cannot be shown
      if (n_all > `SGS_CNT_SAT) begin
        info = `SGS_INFO_MAX;
      end else begin
        info = n_all[5:0];
      end
    end else if (top_code == sgs_pkg::SGS_ERR_MODULE) begin
      info = first_slot(slot_fault);
    end else begin
      // a single general error names no slot
      info = `SGS_INFO_ZERO;
    end
  end

  // assemble the whole word
  always_comb begin
    status_word_nxt = `SGS_RESET_WORD;
    status_word_nxt[`SGS_BIT_ACTIVE] = head_active;
    status_word_nxt[`SGS_BIT_SIM] = sim_active;
    status_word_nxt[`SGS_BIT_FAULT] = any_err;
    status_word_nxt[`SGS_BIT_MODF] = (top_code == sgs_pkg::SGS_ERR_MODULE);
    status_word_nxt[`SGS_CODE_HI:`SGS_CODE_LO] = top_code;
    status_word_nxt[`SGS_BIT_MULTI] = multi;
    status_word_nxt[`SGS_BIT_BUSY] = param_busy;
    status_word_nxt[`SGS_INFO_HI:`SGS_INFO_LO] = info;
  end

  // word register follows its inputs every cycle; no write path exists
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      status_word_r <= `SGS_RESET_WORD;
    end else begin
      status_word_r <= status_word_nxt;
    end
  end

  // downstream bytes shift up by two when the word leads the image
  always_comb begin
    if (status_en) begin
      app_rd_addr = rd_addr - `SGS_HDR_BYTES;
    end else begin
      app_rd_addr = rd_addr;
    end
  end

  // read data: high byte first, then low byte, then module bytes
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rd_data_r <= `SGS_BYTE_ZERO;
    end else if (rd_req) begin
      if (status_en && rd_addr == `SGS_BYTE_HI_IDX) begin
        rd_data_r <= status_word_r[`SGS_BIT_ACTIVE:`SGS_CODE_LO];
      end else if (status_en && rd_addr == `SGS_BYTE_LO_IDX) begin
        rd_data_r <= status_word_r[`SGS_BIT_MULTI:`SGS_INFO_LO];
      end else begin
        rd_data_r <= app_rd_data;
      end
    end
  end

  // one-cycle acknowledge for every read
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rd_ack_r <= 1'b0;
    end else begin
      rd_ack_r <= rd_req;
    end
  end

  // ---------------- checks ----------------

  // active bit follows the head one cycle later
  property p_active;
    @(posedge sys_clk) disable iff (!resetn)
      $changed(head_active) |=> status_word_r[15] == $past(head_active);
  endproperty
  a_active: assert property (p_active) else $error("active bit wrong");

  // simulation bit follows sim_active one cycle later, both levels
  property p_sim;
    @(posedge sys_clk) disable iff (!resetn)
      1'b1 |=> status_word_r[14] == $past(sim_active);
  endproperty
  a_sim: assert property (p_sim) else $error("sim bit not set");

  // fault bit equals a nonzero code
  property p_fault;
    @(posedge sys_clk) disable iff (!resetn)
      status_word_r[13] == (status_word_r[11:8] != 4'h0);
  endproperty
  a_fault: assert property (p_fault) else $error("fault bit and code disagree");

  // module-fault bit only with code 6
  property p_modf;
    @(posedge sys_clk) disable iff (!resetn)
      status_word_r[12] == (status_word_r[11:8] == 4'h6);
  endproperty
  a_modf: assert property (p_modf) else $error("module bit wrong");

  // reserved code never shown
  property p_no_f;
    @(posedge sys_clk) disable iff (!resetn)
      status_word_r[11:8] != 4'hf;
  endproperty
  a_no_f: assert property (p_no_f) else $error("reserved code shown");

  // interface RAM error outranks everything
  property p_prio;
    @(posedge sys_clk) disable iff (!resetn)
      gen_err_pend[1] |=> status_word_r[11:8] == 4'h1;
  endproperty
  a_prio: assert property (p_prio) else $error("priority lost");

  // a slot fault alone yields code 6 and its slot
  property p_single_slot;
    @(posedge sys_clk) disable iff (!resetn)
      ($onehot(slot_fault) && supply_fault == 6'h00
        && (gen_err_pend & `SGS_GEN_MASK) == 16'h0000)
      |=> status_word_r[11:8] == 4'h6 && !status_word_r[7]
        && status_word_r[5:0] == $past(first_slot(slot_fault));
  endproperty
  a_single_slot: assert property (p_single_slot) else $error("slot report wrong");

  // two slot faults give a multiple flag and a count of two
  property p_count;
    @(posedge sys_clk) disable iff (!resetn)
      ($countones(slot_fault) == 2 && supply_fault == 6'h00
        && (gen_err_pend & `SGS_GEN_MASK) == 16'h0000)
      |=> status_word_r[7] && status_word_r[5:0] == 6'h02;
  endproperty
  a_count: assert property (p_count) else $error("error count wrong");

  // supply faults alone give code 7 and the map
  property p_supply;
    @(posedge sys_clk) disable iff (!resetn)
      (supply_fault != 6'h00 && slot_fault == 64'h0
        && (gen_err_pend & `SGS_GEN_MASK) == 16'h0000)
      |=> status_word_r[11:8] == 4'h7 && !status_word_r[7]
        && status_word_r[5:0] == $past(supply_fault);
  endproperty
  a_supply: assert property (p_supply) else $error("supply map wrong");

  // busy bit follows param_busy one cycle later, both levels
  property p_busy;
    @(posedge sys_clk) disable iff (!resetn)
      1'b1 |=> status_word_r[6] == $past(param_busy);
  endproperty
  a_busy: assert property (p_busy) else $error("busy bit stuck");

  // enabled read of byte 0 returns the upper byte one cycle later
  property p_rd_hi;
    @(posedge sys_clk) disable iff (!resetn)
      (rd_req && status_en && rd_addr == 8'h00)
      |=> rd_ack_r && rd_data_r == $past(status_word_r[15:8]);
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper byte read wrong");

  // enabled read of byte 1 returns the lower byte one cycle later
  property p_rd_lo;
    @(posedge sys_clk) disable iff (!resetn)
      (rd_req && status_en && rd_addr == 8'h01)
      |=> rd_ack_r && rd_data_r == $past(status_word_r[7:0]);
  endproperty
  a_rd_lo: assert property (p_rd_lo) else $error("lower byte read wrong");

  // disabled word: reads pass straight to the module image
  property p_rd_off;
    @(posedge sys_clk) disable iff (!resetn)
      (rd_req && !status_en) |=> rd_data_r == $past(app_rd_data);
  endproperty
  a_rd_off: assert property (p_rd_off) else $error("disabled read wrong");

  // stable inputs keep the word stable; the first edge after reset is skipped
  // because the register still holds its reset value there
  property p_stable;
    @(posedge sys_clk) disable iff (!resetn)
      ($past(resetn) && $stable(status_word_nxt)) |=> $stable(status_word_r);
  endproperty
  a_stable: assert property (p_stable) else $error("word changed by itself");

  // scenarios worth seeing
  c_multi: cover property (@(posedge sys_clk) disable iff (!resetn) status_word_r[7]);
  c_supply: cover property (@(posedge sys_clk) disable iff (!resetn)
    status_word_r[11:8] == 4'h7);
  c_slot: cover property (@(posedge sys_clk) disable iff (!resetn)
    status_word_r[12] && !status_word_r[7]);
  c_rd: cover property (@(posedge sys_clk) disable iff (!resetn) rd_req && status_en);

endmodule

// ===== sgs_dp_master.sv
// dp master model: reads cyclic input bytes one at a time
// assumes the read port answers one cycle after the request edge
`timescale 1ns/1ps
module sgs_dp_master (
  // clock
  input wire logic sys_clk,
  // read port
  output logic rd_req,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data_r,
  input wire logic rd_ack_r
);
  // idle until the first read
  initial begin
    rd_req = 1'b0;
    rd_addr = 8'h00;
  end
  // one-cycle request pulse; answer taken in the following cycle
  task automatic read_byte(input logic [7:0] a, output logic [7:0] d, output logic ack);
    @(negedge sys_clk);
    rd_req = 1'b1;
    rd_addr = a;
    @(negedge sys_clk);
    rd_req = 1'b0;
    // address no longer qualified, so move it to expose stale use
    rd_addr = ~a;
    ack = rd_ack_r;
    d = rd_data_r;
  endtask
endmodule

// ===== testbench.sv
// bench for the status word: drives conditions, reads the cyclic bytes
// assumes sgs_consts.svh on the include path and the dp master model
`timescale 1ns/1ps
`include "sgs_consts.svh"
module testbench;
  // clock, reset and condition inputs
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic head_active = 1'b0;
  logic sim_active = 1'b0;
  logic param_busy = 1'b0;
  logic [15:0] gen = 16'h0000;
  logic [63:0] slots = 64'h0;
  logic [5:0] sup = 6'h00;
  logic status_en = 1'b1;
  // read port and downstream image
  logic rd_req, rd_ack_r, a;
  logic [7:0] rd_addr, rd_data_r, app_rd_addr, app_rd_data, d;
  logic [15:0] status_word_r, w;
  int fails = 0;
  int num_checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  // image byte derived from its index, so a wrong offset shows
  assign app_rd_data = app_rd_addr ^ 8'h3c;
  sgs_status_word dut (.sys_clk(sys_clk), .resetn(resetn), .head_active(head_active),
    .sim_active(sim_active), .param_busy(param_busy), .gen_err_pend(gen),
    .slot_fault(slots), .supply_fault(sup), .status_en(status_en), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_data_r(rd_data_r), .rd_ack_r(rd_ack_r),
    .app_rd_addr(app_rd_addr), .app_rd_data(app_rd_data), .status_word_r(status_word_r));
  sgs_dp_master master (.sys_clk(sys_clk), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_data_r(rd_data_r), .rd_ack_r(rd_ack_r));
  // compare tasks, one per kind of result
  task automatic cmp16(input logic [15:0] g, e, m, input string s);
    num_checks++;
    if ((g & m) !== (e & m)) begin
      fails++;
      $display("wrong value at %0t: %s got %h want %h", $time, s, g, e);
    end
  endtask
  task automatic cmp8(input logic [7:0] g, e, input string s);
    cmp16({8'h00, g}, {8'h00, e}, 16'h00ff, s);
  endtask
  task automatic cmp1(input logic g, e, input string s);
    cmp16({15'h0, g}, {15'h0, e}, 16'h0001, s);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  // expected word from the current conditions
  function automatic logic [15:0] expw();
    logic [15:0] g;
    logic [15:0] r;
    int n;
    int c;
    int sl;
    g = gen & `SGS_GEN_MASK;
    n = 0;
    c = 0;
    sl = 0;
    r = 16'h0000;
    // descending scan, so the lowest pending code wins
    for (int i = 15; i > 0; i--) begin
      if (g[i] || (i == 6 && |slots) || (i == 7 && |sup)) c = i;
      if (g[i]) n++;
    end
    for (int s = 63; s >= 0; s--) begin
      if (slots[s]) begin
        n++;
        sl = s;
      end
    end
    for (int k = 0; k < 6; k++) begin
      if (sup[k]) n++;
    end
    r[15] = head_active;
    r[14] = sim_active;
    r[6] = param_busy;
    r[13] = (n != 0);
    r[12] = (c == 6);
    r[11:8] = 4'(c);
    if (g == 16'h0000 && slots == 64'h0 && sup != 6'h00) r[5:0] = sup;
    else if (n > 1) begin
      r[7] = 1'b1;
      r[5:0] = (n > 63) ? 6'h3f : 6'(n);
    end
    else if (c == 6) r[5:0] = 6'(sl);
    return r;
  endfunction
  // apply sources, compare the whole word one edge later
  task automatic wchk(input logic [15:0] g, input logic [63:0] s, input logic [5:0] p);
    @(negedge sys_clk);
    gen = g;
    slots = s;
    sup = p;
    @(negedge sys_clk);
    w = expw();
    cmp16(status_word_r, w, 16'hffff, "word");
  endtask
  // one byte read with its acknowledge pulse
  task automatic rchk(input logic [7:0] ad, e);
    master.read_byte(ad, d, a);
    cmp1(a, 1'b1, "ack");
    cmp8(d, e, "byte");
    @(negedge sys_clk);
    cmp1(rd_ack_r, 1'b0, "ack pulse");
  endtask
  initial begin
    repeat (2) @(negedge sys_clk);
    cmp16(status_word_r, `SGS_RESET_WORD, 16'hffff, "reset word");
    cmp1(rd_ack_r, 1'b0, "reset ack");
    resetn = 1'b1;
    done("reset");
    wchk(16'h0, 64'h10, 6'h0);
    cmp16(status_word_r, 16'h3604, 16'hffff, "slot 4");
    head_active = 1'b1;
    sim_active = 1'b1;
    param_busy = 1'b1;
    wchk(16'h0, 64'h8000_0000_0000_0000, 6'h0);
    sim_active = 1'b0;
    param_busy = 1'b0;
    // every general code alone
    for (int c = 1; c < 15; c++) begin
      if (c != 6 && c != 7) wchk(16'h0001 << c, 64'h0, 6'h0);
    end
    wchk(16'h80c1, 64'h0, 6'h0);
    wchk(16'h0, 64'h0, 6'h2a);
    wchk(16'h0008, 64'h0, 6'h21);
    wchk(16'h0200, 64'h6, 6'h01);
    wchk(16'h0208, 64'h0, 6'h0);
    wchk(16'h0, 64'h6, 6'h0);
    wchk(`SGS_GEN_MASK, '1, 6'h3f);
    wchk(16'h0, 64'h0, 6'h0);
    done("word");
    wchk(16'h0, 64'h10, 6'h0);
    rchk(8'h00, w[15:8]);
    rchk(8'h01, w[7:0]);
    rchk(8'h05, 8'h03 ^ 8'h3c);
    status_en = 1'b0;
    rchk(8'h00, 8'h00 ^ 8'h3c);
    rchk(8'h01, 8'h01 ^ 8'h3c);
    status_en = 1'b1;
    done("read");
    // second reset in mid-run clears at once
    resetn = 1'b0;
    #1;
    cmp16(status_word_r, `SGS_RESET_WORD, 16'hffff, "mid reset");
    @(negedge sys_clk);
    resetn = 1'b1;
    wchk(16'h0400, 64'h0, 6'h0);
    done("mid reset");
    tally_and_finish();
  end
  // watchdog: the tests need about seventy cycles
  initial begin
    #20000;
    fails++;
    tally_and_finish();
  end
endmodule
